//--- rtl/sls_pkg.sv
package sls_pkg;
   // apb register byte offsets
   localparam logic [7:0]  OFF_CTRL       = 8'h00;
   localparam logic [7:0]  OFF_STATUS     = 8'h04;
   localparam logic [7:0]  OFF_IRQ_STAT   = 8'h08;
   localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;
   localparam logic [7:0]  OFF_WDT        = 8'h10;
   // control fields
   localparam int          CTRL_WDT_EN    = 0;
   localparam int          CTRL_LIMIT_LSB = 8;
   localparam logic        RST_WDT_EN     = 1'h1;
   localparam logic [7:0]  RST_LIMIT      = 8'h0F;
   // status fields
   localparam int          STAT_PD        = 0;
   localparam int          STAT_TO        = 1;
   localparam int          STAT_HALTED    = 2;
   localparam logic        RST_PD         = 1'h1;
   localparam logic        RST_TO         = 1'h1;
   // interrupt event bits
   localparam int          EV_HALT        = 0;
   localparam int          EV_WAKE_WDT    = 1;
   localparam int          EV_WAKE_PIN    = 2;
   localparam int          EV_SET_ONES    = 3;
   localparam int          EV_W           = 4;
   localparam logic [3:0]  RST_IRQ_MASK   = 4'h0;
   // opcodes
   localparam logic [15:0] OP_HALT        = 16'h0003;
   localparam logic [6:0]  OP_SET_ONES    = 7'h34;
   localparam logic [7:0]  ONES_VALUE     = 8'hFF;
   // access bank split: low part in bank 0, high part in the top bank
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
   localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
   // instruction phases
   localparam logic [1:0]  Q_DECODE       = 2'h0;
   localparam logic [1:0]  Q_LAST         = 2'h3;
   typedef enum logic [1:0] {
      SLS_MODE_RUN  = 2'b01,
      SLS_MODE_HALT = 2'b10
   } sls_mode_t;
endpackage

//--- rtl/sls_watchdog.sv
`timescale 1ns/1ns
module sls_watchdog #(
   parameter int BASE_W = 8,
   parameter int PS_W   = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // control
   input  wire logic              en,
   input  wire logic              clear,
   input  wire logic [PS_W-1:0]   limit,
   // state
   output logic [BASE_W-1:0]      base_cnt,
   output logic [PS_W-1:0]        ps_cnt,
   output logic                   tick
);
   import sls_pkg::*;

   if (BASE_W < 2 || PS_W < 1 || PS_W > 8) begin : g_bad_width
      $error("sls_watchdog: width out of range");
   end

   typedef struct packed {
      logic [BASE_W-1:0] base;
      logic [PS_W-1:0]   ps;
      logic              tick;
   } sls_wdt_st_t;

   sls_wdt_st_t st;
   sls_wdt_st_t next_st;

   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (clear) begin
         next_st.base = '0;
         next_st.ps   = '0;
      end else if (en) begin
         next_st.base = st.base + 1'b1;
         if (&st.base) begin
            if (st.ps >= limit) begin
               next_st.ps   = '0;
               next_st.tick = 1'b1;
            end else begin
               next_st.ps = st.ps + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign base_cnt = st.base;
   assign ps_cnt   = st.ps;
   assign tick     = st.tick;

   a_wdt_clear_zero : assert property (@(posedge clk) disable iff (rst)
      (ce && clear) |=> (st.base == '0 && st.ps == '0))
      else $error("watchdog not cleared");
endmodule // sls_watchdog

//--- rtl/sls_exec.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - halt instruction clears the power-down flag.
// - halt instruction sets the time-out flag.
// - halt instruction clears watchdog count and its postscaler.
// - after halt the oscillator stops and no instruction runs until wake-up.
// - a watchdog wake-up from halt clears the time-out flag.
module sls_exec #(
   parameter int BASE_W = 8,
   parameter int PS_W   = 8
) (
   // clock, reset, enable
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        CLK_EN,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // instruction stream
   input  wire logic        INSTR_VALID,
   input  wire logic [15:0] INSTR,
   input  wire logic [3:0]  BANK_SELECT_REG,
   output logic             INSTR_TAKEN,
   // wake-up pin
   input  wire logic        WAKE_PIN,
   // data memory write
   output logic             MEM_WE,
   output logic      [11:0] MEM_ADDR,
   output logic      [7:0]  MEM_WDATA,
   // power state
   output logic             POWER_DOWN_FLAG,
   output logic             TIMEOUT_FLAG,
   output logic             HALTED,
   output logic             OSC_RUN,
   output logic             IRQ
);
   import sls_pkg::*;

   // both counts are read back through 8-bit fields of one word
   if (BASE_W < 2 || BASE_W > 8 || PS_W < 1 || PS_W > 8) begin : g_bad_width
      $error("sls_exec: watchdog widths must fit their 8-bit fields");
   end

   typedef struct packed {
      logic [1:0]         q;
      logic               busy;
      logic               is_halt;
      logic               is_ones;
      logic               acc;
      logic [7:0]         f;
      logic [3:0]         bank;
      sls_mode_t          mode;
      logic               osc_run;
      logic               pd;
      logic               to;
      logic               taken;
      logic               mem_we;
      logic [11:0]        mem_addr;
      logic [7:0]         mem_data;
      logic               wake_s1;
      logic               wake_s2;
      logic               wdt_en;
      logic [7:0]         limit;
      logic [EV_W-1:0]    irq_stat;
      logic [EV_W-1:0]    irq_mask;
      logic               irq;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
   } sls_core_st_t;

   sls_core_st_t       st;
   sls_core_st_t       next_st;
   logic               wdt_clear;
   logic               wdt_tick;
   logic [BASE_W-1:0]  wdt_base;
   logic [PS_W-1:0]    wdt_ps;
   logic               exec_halt;
   logic               exec_ones;
   logic               apb_access;
   logic [4:0]         sel;
   logic [EV_W-1:0]    ev;

   // one-hot register select; all zero means unmapped
   function automatic logic [4:0] reg_sel(input logic [7:0] a);
      reg_sel = {a == OFF_WDT, a == OFF_IRQ_MASK, a == OFF_IRQ_STAT,
                 a == OFF_STATUS, a == OFF_CTRL};
   endfunction

   // file register address for the access bit
   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                             input logic [3:0] bank_select_reg);
      if (a) begin
         file_addr = {bank_select_reg, f};
      end else if (f < ACCESS_SPLIT) begin
         file_addr = {ACCESS_LO_BANK, f};
      end else begin
         file_addr = {ACCESS_HI_BANK, f};
      end
   endfunction

   sls_watchdog #(
      .BASE_W (BASE_W),
      .PS_W   (PS_W)
   ) u_wdt (
      .clk      (CORE_CLK),
      .rst      (RST),
      .ce       (CLK_EN),
      .en       (st.wdt_en),
      .clear    (wdt_clear),
      .limit    (st.limit[PS_W-1:0]),
      .base_cnt (wdt_base),
      .ps_cnt   (wdt_ps),
      .tick     (wdt_tick)
   );

   assign exec_halt  = st.mode == SLS_MODE_RUN && st.busy && st.q == Q_LAST && st.is_halt;
   assign exec_ones  = st.mode == SLS_MODE_RUN && st.busy && st.q == Q_LAST && st.is_ones;
   assign apb_access = PSEL && PENABLE && st.pready;
   assign sel        = reg_sel(PADDR);
   assign wdt_clear  = exec_halt;

   always_comb begin
      next_st        = st;
      next_st.taken  = 1'b0;
      next_st.mem_we = 1'b0;
      ev             = '0;
      // wake pin crosses in from outside the clock
      next_st.wake_s1 = WAKE_PIN;
      next_st.wake_s2 = st.wake_s1;
      unique case (st.mode)
         SLS_MODE_RUN: begin
            next_st.q = st.q + 2'h1;
            if (st.q == Q_DECODE && INSTR_VALID) begin
               next_st.busy    = 1'b1;
               next_st.taken   = 1'b1;
               next_st.is_halt = INSTR == OP_HALT;
               next_st.is_ones = INSTR[15:9] == OP_SET_ONES;
               next_st.acc     = INSTR[8];
               next_st.f       = INSTR[7:0];
               next_st.bank    = BANK_SELECT_REG;
            end
            if (st.q == Q_LAST) begin
               next_st.busy = 1'b0;
            end
            if (exec_ones) begin
               // flags deliberately left alone
               next_st.mem_we   = 1'b1;
               next_st.mem_addr = file_addr(st.acc, st.f, st.bank);
               next_st.mem_data = ONES_VALUE;
               ev[EV_SET_ONES]  = 1'b1;
            end
            if (exec_halt) begin
               next_st.pd      = 1'b0;
               next_st.to      = 1'b1;
               next_st.mode    = SLS_MODE_HALT;
               next_st.osc_run = 1'b0;
               ev[EV_HALT]     = 1'b1;
            end
         end
         SLS_MODE_HALT: begin
            // phase counter frozen: no instruction advances while halted
            if (wdt_tick) begin
               next_st.to       = 1'b0;
               next_st.mode     = SLS_MODE_RUN;
               next_st.osc_run  = 1'b1;
               next_st.q        = Q_DECODE;
               ev[EV_WAKE_WDT]  = 1'b1;
            end else if (st.wake_s2) begin
               next_st.mode     = SLS_MODE_RUN;
               next_st.osc_run  = 1'b1;
               next_st.q        = Q_DECODE;
               ev[EV_WAKE_PIN]  = 1'b1;
            end
         end
      endcase
      // apb: answer in the first access cycle
      next_st.pready = PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
         next_st.pslverr = sel == 5'h00;
         next_st.prdata  = 32'h0000_0000;
         if (sel[0]) next_st.prdata = {16'h0000, st.limit, 7'h00, st.wdt_en};
         if (sel[1]) next_st.prdata = {29'h0, st.mode == SLS_MODE_HALT, st.to, st.pd};
         if (sel[2]) next_st.prdata = {28'h0, st.irq_stat};
         if (sel[3]) next_st.prdata = {28'h0, st.irq_mask};
         if (sel[4]) next_st.prdata = {16'h0000, 8'(wdt_ps), 8'(wdt_base)};
      end
      if (apb_access && PWRITE && sel[0]) begin
         next_st.wdt_en = PWDATA[CTRL_WDT_EN];
         next_st.limit  = PWDATA[CTRL_LIMIT_LSB +: 8];
      end
      if (apb_access && PWRITE && sel[3]) begin
         next_st.irq_mask = PWDATA[EV_W-1:0];
      end
      if (apb_access && !PWRITE && sel[2]) begin
         next_st.irq_stat = '0;
      end
      // a new event wins over the read clear
      next_st.irq_stat = next_st.irq_stat | ev;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         st          <= '0;
         st.mode     <= SLS_MODE_RUN;
         st.osc_run  <= 1'b1;
         st.pd       <= RST_PD;
         st.to       <= RST_TO;
         st.wdt_en   <= RST_WDT_EN;
         st.limit    <= RST_LIMIT;
         st.irq_mask <= RST_IRQ_MASK;
      end else if (CLK_EN) begin
         st <= next_st;
      end
   end

   assign PRDATA          = st.prdata;
   assign PREADY          = st.pready;
   assign PSLVERR         = st.pslverr;
   assign INSTR_TAKEN     = st.taken;
   assign MEM_WE          = st.mem_we;
   assign MEM_ADDR        = st.mem_addr;
   assign MEM_WDATA       = st.mem_data;
   assign POWER_DOWN_FLAG = st.pd;
   assign TIMEOUT_FLAG    = st.to;
   // one-hot: bit 1 is the halt state, so the pin comes straight from a flop
   assign HALTED          = st.mode[1];
   assign OSC_RUN         = st.osc_run;
   assign IRQ             = st.irq;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   a_halt_pd_clear : assert property ((CLK_EN && exec_halt) |=> !POWER_DOWN_FLAG)
      else $error("power-down flag not cleared by halt");
   a_halt_to_set : assert property ((CLK_EN && exec_halt) |=> TIMEOUT_FLAG && HALTED)
      else $error("time-out flag not set by halt");
   a_halt_wdt_zero : assert property ((CLK_EN && exec_halt) |=> wdt_base == '0 && wdt_ps == '0)
      else $error("watchdog not cleared by halt");
   a_halt_osc_off : assert property (HALTED |-> !OSC_RUN && !MEM_WE && !INSTR_TAKEN)
      else $error("core active while halted");
   a_halt_q_frozen : assert property ((CLK_EN && HALTED && !wdt_tick && !st.wake_s2)
      |=> HALTED && $stable(st.q))
      else $error("phase advanced while halted");
   a_wdt_wake_to : assert property ((CLK_EN && HALTED && wdt_tick)
      |=> !TIMEOUT_FLAG && !HALTED && OSC_RUN)
      else $error("watchdog wake did not clear time-out");
   a_ones_data : assert property ((CLK_EN && exec_ones) |=> MEM_WE && MEM_WDATA == 8'hFF
      && $stable(POWER_DOWN_FLAG) && $stable(TIMEOUT_FLAG))
      else $error("set-ones write wrong");
   a_ones_bank : assert property ((CLK_EN && exec_ones && !st.acc && st.f < ACCESS_SPLIT)
      |=> MEM_ADDR == {4'h0, $past(st.f)})
      else $error("access bank address wrong");
   a_ones_bsr : assert property ((CLK_EN && exec_ones && st.acc)
      |=> MEM_ADDR[11:8] == $past(st.bank))
      else $error("bank select address wrong");
   a_irq_level : assert property (IRQ == |(st.irq_stat & st.irq_mask))
      else $error("interrupt level wrong");

   c_halt   : cover property (CLK_EN && exec_halt);
   c_wdt_wk : cover property (CLK_EN && HALTED && wdt_tick);
   c_pin_wk : cover property (CLK_EN && HALTED && !wdt_tick && st.wake_s2);
   c_ones   : cover property (CLK_EN && exec_ones ##4 CLK_EN && exec_ones);
endmodule // sls_exec

//--- tb/sls_exec_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module sls_exec_tb;
   import sls_pkg::*;
   logic        CORE_CLK, RST, CLK_EN, PSEL, PENABLE, PWRITE, INSTR_VALID, WAKE_PIN;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic        PREADY, PSLVERR, INSTR_TAKEN, MEM_WE, POWER_DOWN_FLAG, TIMEOUT_FLAG;
   logic        HALTED, OSC_RUN, IRQ;
   logic [15:0] INSTR;
   logic [3:0]  BANK_SELECT_REG;
   logic [11:0] MEM_ADDR;
   logic [7:0]  MEM_WDATA;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch, total_checks;
   // narrow base count so a postscaler limit of 0 ticks every 4 cycles
   sls_exec #(.BASE_W(2), .PS_W(8)) sls_exec_inst (
      .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .BANK_SELECT_REG(BANK_SELECT_REG),
      .INSTR_TAKEN(INSTR_TAKEN), .WAKE_PIN(WAKE_PIN),
      .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
      .POWER_DOWN_FLAG(POWER_DOWN_FLAG), .TIMEOUT_FLAG(TIMEOUT_FLAG),
      .HALTED(HALTED), .OSC_RUN(OSC_RUN), .IRQ(IRQ)
   );
   initial begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // apb transfer; the wait for pready is bounded by the watchdog process only
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge CORE_CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= addr;
      PWDATA  <= wdata;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      rd  = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // returns just after the edge at which the instruction's effects land
   task automatic exec(input logic [15:0] op, input logic [3:0] bank);
      int i;
      @(posedge CORE_CLK);
      INSTR_VALID     <= 1'b1;
      INSTR           <= op;
      BANK_SELECT_REG <= bank;
      for (i = 0; i < 10; i++) begin
         @(posedge CORE_CLK);
         #1;
         if (INSTR_TAKEN === 1'b1) break;
      end
      `CHK(INSTR_TAKEN, 1'b1)
      @(posedge CORE_CLK);
      INSTR_VALID <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      #1;
   endtask
   task automatic wait_halt(input logic v);
      for (int i = 0; i < 40; i++) begin
         @(posedge CORE_CLK);
         #1;
         if (HALTED === v) return;
      end
   endtask
   logic [7:0]  f_tab [3] = '{8'h5F, 8'h60, 8'h12};
   logic        a_tab [3] = '{1'b0, 1'b0, 1'b1};
   logic [11:0] e_tab [3] = '{12'h05F, 12'hF60, 12'h712};
   initial begin
      RST = 1'b1; CLK_EN = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
      PADDR = 8'h00; PWDATA = 32'h0; INSTR_VALID = 1'b0; INSTR = 16'h0000;
      BANK_SELECT_REG = 4'h0; WAKE_PIN = 1'b0; n_mismatch = 0; total_checks = 0;
      repeat (12) @(posedge CORE_CLK);
      RST <= 1'b0;
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd, 32'h00000003)
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(rd, 32'h00000F01)
      apb(1'b0, OFF_IRQ_MASK, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b0, 8'h14, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("test reset values done");
      apb(1'b1, OFF_IRQ_MASK, 32'h00000008);
      for (int k = 0; k < 3; k++) begin
         exec({OP_SET_ONES, a_tab[k], f_tab[k]}, 4'h7);
         `CHK({MEM_WE, MEM_ADDR, MEM_WDATA}, {1'b1, e_tab[k], ONES_VALUE})
         `CHK({POWER_DOWN_FLAG, TIMEOUT_FLAG}, 2'b11)
      end
      `CHK(IRQ, 1'b1)
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h00000008)
      @(posedge CORE_CLK);
      #1;
      `CHK(IRQ, 1'b0)
      $display("test set ones done");
      // watchdog frozen so the count seen after halt must come from the clear
      apb(1'b1, OFF_CTRL, 32'h00000000);
      exec(OP_HALT, 4'h0);
      `CHK(POWER_DOWN_FLAG, 1'b0)
      `CHK(TIMEOUT_FLAG, 1'b1)
      `CHK({HALTED, OSC_RUN}, 2'b10)
      apb(1'b0, OFF_WDT, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd, 32'h00000006)
      @(posedge CORE_CLK);
      INSTR_VALID <= 1'b1;
      INSTR       <= {OP_SET_ONES, 1'b0, 8'h20};
      repeat (8) begin
         @(posedge CORE_CLK);
         #1;
         `CHK({INSTR_TAKEN, MEM_WE}, 2'b00)
      end
      @(posedge CORE_CLK);
      INSTR_VALID <= 1'b0;
      WAKE_PIN    <= 1'b1;
      wait_halt(1'b0);
      `CHK({HALTED, OSC_RUN, TIMEOUT_FLAG}, 3'b011)
      @(posedge CORE_CLK);
      WAKE_PIN <= 1'b0;
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h00000005)
      $display("test halt and pin wake done");
      apb(1'b1, OFF_CTRL, 32'h00000001);
      exec(OP_HALT, 4'h0);
      `CHK({HALTED, POWER_DOWN_FLAG, TIMEOUT_FLAG}, 3'b101)
      // clock enable low freezes the watchdog, so the core must stay halted
      @(posedge CORE_CLK);
      CLK_EN <= 1'b0;
      repeat (20) @(posedge CORE_CLK);
      #1;
      `CHK({HALTED, OSC_RUN}, 2'b10)
      @(posedge CORE_CLK);
      CLK_EN <= 1'b1;
      wait_halt(1'b0);
      `CHK({HALTED, OSC_RUN, TIMEOUT_FLAG}, 3'b010)
      `CHK(POWER_DOWN_FLAG, 1'b0)
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h00000003)
      $display("test halt and watchdog wake done");
      // a reset in mid-run must bring back the power-up values
      @(posedge CORE_CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd, 32'h00000003)
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(rd, 32'h00000F01)
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h00000000)
      $display("test mid-run reset done");
      print_verdict();
   end
   initial begin
      #(40 * 20000);
      n_mismatch++;
      print_verdict();
   end
endmodule // sls_exec_tb
